// *** pkg/itel_defs.vh ***
`ifndef ITEL_DEFS_VH
`define ITEL_DEFS_VH
// Register offsets (byte addresses)
`define ITEL_OFF_CTRL      8'h00
`define ITEL_OFF_STAT      8'h04
`define ITEL_OFF_EVT       8'h08
`define ITEL_OFF_SAVED     8'h0C
`define ITEL_OFF_CODE      8'h10
`define ITEL_OFF_PREG      8'h14
`define ITEL_OFF_PVAL      8'h18
// Status longword bit positions
`define ITEL_TE_BIT        30
`define ITEL_TP_BIT        27
`define ITEL_CM_BIT        31
// Reset value of the status word
`define ITEL_STAT_RST      32'h0000_0000
// Exception classes
`define ITEL_EX_NONE       4'h0
`define ITEL_EX_TRACE      4'h1
`define ITEL_EX_RSVOPC     4'h2
`define ITEL_EX_CUSTOPC    4'h3
`define ITEL_EX_RSVOPD_F   4'h4
`define ITEL_EX_RSVOPD_A   4'h5
`define ITEL_EX_BREAK      4'h6
`define ITEL_EX_COMPAT     4'h7
`define ITEL_EX_NATIVE     4'h8
// Compatibility codes
`define ITEL_CC_RSVOPC     32'h0000_0000
`define ITEL_CC_ODDADDR    32'h0000_0006
// Opcodes
`define ITEL_OPC_ALLF      16'hFFFF
`define ITEL_OPC_CUST      8'hFC
`define ITEL_OPC_BREAK     8'h03
// Processor register numbers
`define ITEL_PR_R0BASE     6'h08
`define ITEL_PR_R0LEN      6'h09
`define ITEL_PR_R1BASE     6'h0A
`define ITEL_PR_R1LEN      6'h0B
`define ITEL_PR_ASYNC_TRAP_LEVEL     6'h13
`define ITEL_PR_SWINT      6'h15
`define ITEL_PR_MAXNUM     6'h3F
// Address window limits and the highest legal trap level
`define ITEL_R0B_LO        32'h8000_0000
`define ITEL_R0B_HI        32'hBFFF_FFFF
`define ITEL_R1B_LO        32'h7F80_0000
`define ITEL_R1B_HI        32'hBF7F_FFFF
`define ITEL_AST_MAX       3'h4
`endif

// *** src/itel_exception_unit.v ***
`timescale 1ns/10ps
`include "itel_defs.vh"
module itel_exception_unit (
  input  wire        clk,
  input  wire        rst_b,
  // Sequencer events, one-cycle pulses
  input  wire        insnStart,      // Start of instruction
  input  wire [15:0] opcode,         // Opcode, first byte in [7:0]
  input  wire        opcDefined,     // Opcode known to decoder
  input  wire        opcPrivOk,      // Current mode privileged enough
  input  wire        insnDone,       // Instruction completed
  input  wire        opdFaultErr,    // Fault-class operand error
  input  wire        opdAbortErr,    // Abort-class operand error
  input  wire        otherFault,     // Other fault mid-instruction
  input  wire        otherAbort,     // Abort or arithmetic trap
  input  wire        intrMid,        // Interrupt mid-instruction
  input  wire        intrBetween,    // Interrupt after completion
  input  wire        compatFault,    // Compat exception, code below
  input  wire [2:0]  compatCode,     // Compat code 1..6
  input  wire        chmExec,        // Change mode executed
  input  wire        callExec,       // Procedure call executed
  input  wire        reiExec,        // Return from exception
  input  wire        reiSavedTp,     // Restored pending bit
  input  wire        reiSavedTe,     // Restored enable bit
  input  wire        bitSetTe,       // Bit-set sets enable
  input  wire        bitClrTe,       // Bit-clear clears enable
  input  wire        mtprExec,       // Processor register write
  input  wire [5:0]  mtprNum,        // Register number
  input  wire [31:0] mtprData,       // Written value
  // Exception result
  output reg         excValid,       // Exception initiated
  output reg  [3:0]  excClass,       // Exception class
  output reg         excBackupPc,    // Push start-of-instruction PC
  output reg  [31:0] excSavedPsl,    // Status longword pushed
  output reg  [31:0] excCode,        // Compat code pushed
  output reg         excPushCode,    // Code longword is pushed
  output reg         callSavedTe,    // Enable bit for call frame
  output wire        traceEnable,    // Live enable bit
  output wire        tracePending,   // Live pending bit
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  reg  [31:0] psl_r;        // Live status longword
  // No extra state for bit-set: the start-of-instruction load delays it
  reg  [31:0] ctrl_r;       // Bit0 enables register screening
  reg  [31:0] evtCnt_r;     // Count of exceptions taken
  reg  [31:0] prVal_r;      // Last screened value
  reg  [5:0]  prNum_r;      // Last screened register
  reg         awHeld_r;     // Write address captured
  reg         wHeld_r;      // Write data captured
  reg  [7:0]  awAddr_r;
  reg  [31:0] wData_r;
  reg  [3:0]  wStrb_r;

  reg  [31:0] psl_nxt;      // Status after this cycle's events
  reg         regBad;
  reg         opcBad;
  reg         fire;
  reg  [3:0]  cls;
  reg         backup;
  reg  [31:0] pushPsl;
  reg         pushCode;
  reg  [31:0] code;

  assign traceEnable  = psl_r[`ITEL_TE_BIT];
  assign tracePending = psl_r[`ITEL_TP_BIT];

  // Screen processor register writes for illegal values
  always @* begin
    regBad = 1'b0;
    if (mtprNum > `ITEL_PR_MAXNUM) begin
      regBad = 1'b1;
    end
    case (mtprNum)
      `ITEL_PR_R0BASE: regBad = (mtprData[1:0] != 2'h0) || (mtprData < `ITEL_R0B_LO) ||
                                (mtprData > `ITEL_R0B_HI);
      `ITEL_PR_R1BASE: regBad = (mtprData[1:0] != 2'h0) || (mtprData < `ITEL_R1B_LO) ||
                                (mtprData > `ITEL_R1B_HI);
      `ITEL_PR_R0LEN:  regBad = (mtprData[31:27] != 5'h00) || (mtprData[23:22] != 2'h0);
      `ITEL_PR_R1LEN:  regBad = (mtprData[30:22] != 9'h000);
      `ITEL_PR_ASYNC_TRAP_LEVEL: regBad = (mtprData[2:0] > `ITEL_AST_MAX);
      `ITEL_PR_SWINT:  regBad = (mtprData[31:16] != 16'h0000) || mtprData[0];
      default:         regBad = 1'b0;
    endcase
    // Screening can be turned off since it is optional
    regBad = regBad && ctrl_r[0];
  end

  always @* begin
    opcBad = !opcDefined || !opcPrivOk || (opcode == `ITEL_OPC_ALLF);
  end

  // Exception selection and trace bit sequencing
  always @* begin
    psl_nxt  = psl_r;
    // Defaults: nothing fires and the status holds
    fire     = 1'b0;
    cls      = `ITEL_EX_NONE;
    backup   = 1'b0;
    pushPsl  = psl_r;
    pushCode = 1'b0;
    code     = `ITEL_CC_RSVOPC;
    callSavedTe = psl_r[`ITEL_TE_BIT];
    if (insnStart) begin
      if (psl_r[`ITEL_TP_BIT]) begin
        psl_nxt[`ITEL_TP_BIT] = 1'b0;
        pushPsl[`ITEL_TP_BIT] = 1'b0;
        fire = 1'b1;
        cls  = `ITEL_EX_TRACE;
      end else begin
        psl_nxt[`ITEL_TP_BIT] = psl_r[`ITEL_TE_BIT];
        // A bit-set enable therefore first traces the second instruction
        // opcode checks after trace check
        if (opcBad || opcode[7:0] == `ITEL_OPC_CUST) begin
          fire   = 1'b1;
          backup = 1'b1;
          pushPsl[`ITEL_TP_BIT] = 1'b0;
          psl_nxt[`ITEL_TP_BIT] = 1'b0;
          // compat mode reserved opcode code 0
          if (psl_r[`ITEL_CM_BIT]) begin
            cls = `ITEL_EX_COMPAT;
            pushCode = 1'b1;
          end else if (opcode[7:0] == `ITEL_OPC_CUST && opcode != `ITEL_OPC_ALLF && !opcBad) begin
            cls = `ITEL_EX_CUSTOPC;
          end else begin
            cls = `ITEL_EX_RSVOPC;
          end
        end else if (opcode[7:0] == `ITEL_OPC_BREAK && !psl_r[`ITEL_CM_BIT]) begin
          fire = 1'b1;
          cls  = `ITEL_EX_BREAK;
          backup = 1'b1;
          pushPsl[`ITEL_TP_BIT] = 1'b0;
          psl_nxt[`ITEL_TP_BIT] = 1'b0;
        end
      end
    // faults and mid interrupts clear pending
    end else if (opdFaultErr || (mtprExec && regBad) || otherFault || intrMid || compatFault) begin
      fire   = 1'b1;
      backup = 1'b1;
      psl_nxt[`ITEL_TP_BIT] = 1'b0;
      pushPsl[`ITEL_TP_BIT] = 1'b0;
      if (opdFaultErr || (mtprExec && regBad)) begin
        cls = `ITEL_EX_RSVOPD_F;
      end else if (compatFault) begin
        cls = `ITEL_EX_COMPAT;
        pushCode = 1'b1;
        code = {29'h0, compatCode};
      end else begin
        cls = `ITEL_EX_NATIVE;
      end
    // abort or trap leaves pending alone
    end else if (opdAbortErr || otherAbort) begin
      fire   = 1'b1;
      backup = opdAbortErr;
      cls    = opdAbortErr ? `ITEL_EX_RSVOPD_A : `ITEL_EX_NATIVE;
    end else if (intrBetween) begin
      fire = 1'b1;
      cls  = `ITEL_EX_NATIVE;
    end else if (chmExec) begin
      fire = 1'b1;
      cls  = `ITEL_EX_NATIVE;
      pushPsl[`ITEL_TP_BIT] = psl_r[`ITEL_TE_BIT] | psl_r[`ITEL_TP_BIT];
      psl_nxt[`ITEL_TE_BIT] = 1'b0;
      psl_nxt[`ITEL_TP_BIT] = 1'b0;
    end else if (reiExec) begin
      // pending from old enable or saved
      psl_nxt[`ITEL_TP_BIT] = psl_r[`ITEL_TE_BIT] | reiSavedTp;
      psl_nxt[`ITEL_TE_BIT] = reiSavedTe;
    end else if (bitSetTe) begin
      // Pending stays as it is until the next start loads it
      psl_nxt[`ITEL_TE_BIT] = 1'b1;
    end else if (bitClrTe) begin
      psl_nxt[`ITEL_TE_BIT] = 1'b0;
    end
    if (callExec) begin
      callSavedTe = 1'b0;
    end
    // Any exception leaves the handler untraced
    if (fire) begin
      psl_nxt[`ITEL_TE_BIT] = 1'b0;
      psl_nxt[`ITEL_TP_BIT] = 1'b0;
      psl_nxt[`ITEL_CM_BIT] = 1'b0;
    end
  end

  // Status state and exception outputs
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Nothing pending or enabled out of reset
      psl_r       <= `ITEL_STAT_RST;
      excValid    <= 1'b0;
      excClass    <= `ITEL_EX_NONE;
      excBackupPc <= 1'b0;
      excSavedPsl <= 32'h0000_0000;
      excCode     <= 32'h0000_0000;
      excPushCode <= 1'b0;
      evtCnt_r    <= 32'h0000_0000;
      prNum_r     <= 6'h00;
      prVal_r     <= 32'h0000_0000;
    end else begin
      psl_r       <= psl_nxt;
      // Exception outputs below stand for one cycle
      excValid    <= fire;
      excClass    <= cls;
      excBackupPc <= backup;
      excSavedPsl <= pushPsl;
      excCode     <= code;
      excPushCode <= pushCode;
      if (fire) begin
        evtCnt_r <= evtCnt_r + 32'h0000_0001;
      end
      if (mtprExec) begin
        prNum_r <= mtprNum;
        prVal_r <= mtprData;
      end
      // Software write of status, lower priority than exceptions and instruction starts only
      if (awHeld_r && wHeld_r && awAddr_r == `ITEL_OFF_STAT && !fire && !insnStart) begin
        psl_r <= wData_r;
      end
    end
  end

  // AXI4-Lite write side: take address and data in either order
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_r     <= 1'b0;
      wHeld_r      <= 1'b0;
      awAddr_r     <= 8'h00;
      wData_r      <= 32'h0000_0000;
      wStrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      ctrl_r       <= 32'h0000_0001;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      // Both halves present: commit and answer
      if (awHeld_r && wHeld_r) begin
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_r == `ITEL_OFF_CTRL || awAddr_r == `ITEL_OFF_STAT) ? 2'h0 : 2'h2;
        if (awAddr_r == `ITEL_OFF_CTRL && wStrb_r[0]) begin
          ctrl_r <= {31'h0, wData_r[0]};
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read side, one-cycle answer
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        `ITEL_OFF_CTRL:  s_axi_rdata <= ctrl_r;
        `ITEL_OFF_STAT:  s_axi_rdata <= psl_r;
        `ITEL_OFF_EVT:   s_axi_rdata <= evtCnt_r;
        `ITEL_OFF_SAVED: s_axi_rdata <= excSavedPsl;
        `ITEL_OFF_CODE:  s_axi_rdata <= excCode;
        `ITEL_OFF_PREG:  s_axi_rdata <= {26'h0, prNum_r};
        `ITEL_OFF_PVAL:  s_axi_rdata <= prVal_r;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// *** testbench/itel_exception_unit_props.sv ***
`timescale 1ns/10ps
module itel_exception_unit_props (
  input wire        clk,
  input wire        rst_b,
  input wire        insnStart,
  input wire [15:0] opcode,
  input wire        opcDefined,
  input wire        opcPrivOk,
  input wire        opdFaultErr,
  input wire        opdAbortErr,
  input wire        otherFault,
  input wire        otherAbort,
  input wire        intrMid,
  input wire        intrBetween,
  input wire        compatFault,
  input wire [2:0]  compatCode,
  input wire        chmExec,
  input wire        callExec,
  input wire        reiExec,
  input wire        reiSavedTp,
  input wire        excValid,
  input wire [3:0]  excClass,
  input wire [31:0] excSavedPsl,
  input wire [31:0] excCode,
  input wire        excPushCode,
  input wire        callSavedTe,
  input wire        traceEnable,
  input wire        tracePending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // No start, operand error, other fault or abort, or interrupt competes; compat faults and register writes are not excluded
  wire quiet = !insnStart && !opdFaultErr && !opdAbortErr && !otherFault && !otherAbort && !intrMid && !intrBetween;
  // Start with pending set, then the trace fault with pending cleared
  sequence s_traced_start;
    insnStart && tracePending;
  endsequence
  sequence s_trace_taken;
    excValid && excClass == 4'h1 && !excSavedPsl[27] && !tracePending;
  endsequence
  chk_trace_first: assert property (s_traced_start |=> s_trace_taken)
    else $error("trace fault not taken first");
  chk_allf_opcode: assert property (insnStart && !tracePending && opcode == 16'hFFFF
    |=> excValid && excClass == (excSavedPsl[31] ? 4'h7 : 4'h2)) else $error("all-ones opcode did not fault");
  chk_cust_vector: assert property (insnStart && !tracePending && opcode[7:0] == 8'hFC
    && opcDefined && opcPrivOk |=> excValid && excClass == (excSavedPsl[31] ? 4'h7 : 4'h3))
    else $error("customer opcode missed its vector");
  chk_compat_code: assert property (compatFault && quiet
    |=> excValid && excClass == 4'h7 && excPushCode && excCode == {29'h0, $past(compatCode)})
    else $error("compat code wrong");
  chk_fault_clears: assert property ((otherFault || intrMid) && !insnStart |=> excValid && !excSavedPsl[27])
    else $error("fault pushed pending set");
  chk_abort_keeps: assert property (otherAbort && !insnStart && !otherFault && !intrMid && !opdFaultErr
    && !compatFault |=> excValid && excSavedPsl[27] == $past(tracePending)) else $error("abort changed pending");
  chk_chm_saves: assert property (chmExec && traceEnable && quiet && !compatFault
    |=> excValid && excSavedPsl[30] && excSavedPsl[27] && !traceEnable && !tracePending)
    else $error("change mode bits");
  chk_rei_pending: assert property (reiExec && (traceEnable || reiSavedTp) && quiet && !compatFault
    && !chmExec |=> tracePending) else $error("return left pending clear");
  chk_call_frame: assert property (callExec |-> !callSavedTe)
    else $error("call frame saved enable set");
endmodule
bind itel_exception_unit itel_exception_unit_props i_itel_exception_unit_props (.*);

// *** testbench/itel_seq_model.sv ***
`timescale 1ns/10ps
// Sequencer stand-in: turns bench requests into one-cycle event pulses
module itel_seq_model (
  input  wire        clk,
  input  wire [14:0] req,     // Requested events
  input  wire [60:0] qual,    // Qualifiers for them
  output reg  [14:0] evt,     // Event pulses to the block
  output reg  [60:0] evtQual  // Qualifiers, scrambled between pulses
);
  initial evt = 15'h0000;
  initial evtQual = 61'h0;
  // Qualifiers mean nothing between pulses, so never leave them steady
  always @(posedge clk) begin
    evt <= req;
    evtQual <= (|req) ? qual : ~evtQual;
  end
endmodule

// *** testbench/itel_exception_unit_tb.sv ***
`timescale 1ns/10ps
`include "itel_defs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errCount++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module itel_exception_unit_tb;
  localparam int START = 14, OPDF = 13, CMPF = 7, CHM = 6, CALL = 5, RETURN_FROM_EXCEPTION = 4, BSET = 3, BCLR = 2, MOVE_TO_PROCESSOR_REGISTER = 1;
  localparam [31:0] TE = 32'h4000_0000;  // Enable bit alone
  localparam [31:0] TP = 32'h0800_0000;  // Pending bit alone
  logic clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic [14:0] req;
  logic [60:0] qual;
  wire  [14:0] evt;
  wire  [60:0] q;
  wire excValid, excBackupPc, excPushCode, callSavedTe, traceEnable, tracePending;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [3:0]  excClass;
  wire [31:0] excSavedPsl, excCode, s_axi_rdata;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  int errCount, compares, i;
  logic [5:0]  note;                     // Expected class, saved enable, saved pending
  logic [5:0]  expQ[$];                  // Notes of exceptions still to come
  logic [15:0] rop;                      // Random ordinary opcode
  logic [15:0] oT[5] = '{16'hFFFF, 16'h0040, 16'h0040, 16'h5AFC, 16'h0003};
  logic [3:0]  cT[5] = '{`ITEL_EX_RSVOPC, `ITEL_EX_RSVOPC, `ITEL_EX_RSVOPC, `ITEL_EX_CUSTOPC, `ITEL_EX_BREAK};
  logic [5:0]  nT[4] = '{`ITEL_PR_ASYNC_TRAP_LEVEL, `ITEL_PR_ASYNC_TRAP_LEVEL, `ITEL_PR_R0BASE, `ITEL_PR_R0BASE};
  logic [31:0] vT[4] = '{32'h5, 32'h0, 32'h8000_0001, 32'h8000_0004};
  itel_seq_model i_itel_seq_model (.clk(clk), .req(req), .qual(qual), .evt(evt), .evtQual(q));
  itel_exception_unit i_itel_exception_unit (.*, .insnStart(evt[14]), .opdFaultErr(evt[13]), .opdAbortErr(evt[12]),
    .otherFault(evt[11]), .otherAbort(evt[10]), .intrMid(evt[9]), .intrBetween(evt[8]), .compatFault(evt[7]),
    .chmExec(evt[6]), .callExec(evt[5]), .reiExec(evt[4]), .bitSetTe(evt[3]), .bitClrTe(evt[2]), .mtprExec(evt[1]),
    .insnDone(evt[0]), .opcode(q[60:45]), .opcDefined(q[44]), .opcPrivOk(q[43]), .compatCode(q[42:40]),
    .reiSavedTp(q[39]), .reiSavedTe(q[38]), .mtprNum(q[37:32]), .mtprData(q[31:0]));
  function automatic [60:0] qo(input [15:0] o, input d, input p);
    qo = {o, d, p, 43'h0};
  endfunction
  // Print counts and the verdict, then stop
  task conclude;
    $display("Comparisons %0d, mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One event through the sequencer; the answer lands two edges later
  task ev(input int b, input [60:0] qv, input bit exp, input [5:0] nt);
    req <= 15'h1 << b;
    qual <= qv;
    if (exp) expQ.push_back(nt);
    @(posedge clk);
    req <= 15'h0000;
    repeat (2) @(posedge clk);
  endtask
  // One register access; valid drops only at the edge that takes it
  task axi(input bit wr, input [7:0] a, input [31:0] d, input [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 40);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (!(wr ? s_axi_bvalid : s_axi_rvalid)) begin
      errCount++;
      conclude();
    end
    if (wr) `CHK(s_axi_bresp, er)
    else begin
      `CHK(s_axi_rresp, er)
      `CHK(s_axi_rdata, d)
    end
    // Let an edge pass so the next access never re-drives a strobe in the same step
    @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Each exception seen is matched against the oldest note; class F is a free class
  always @(posedge clk) begin
    if (rst_b && excValid && expQ.size() == 0) `CHK(excValid, 1'b0)
    else if (rst_b && excValid) begin
      note = expQ.pop_front();
      if (note[5:2] != 4'hF) `CHK(excClass, note[5:2])
      `CHK({excSavedPsl[30], excSavedPsl[27]}, note[1:0])
      if (note[5:2] != 4'hF) `CHK(excPushCode, note[5:2] == `ITEL_EX_COMPAT)
      if (note[5:2] inside {`ITEL_EX_RSVOPC, `ITEL_EX_CUSTOPC, `ITEL_EX_RSVOPD_F, `ITEL_EX_RSVOPD_A, `ITEL_EX_BREAK})
        `CHK(excBackupPc, 1'b1)
    end
  end
  initial begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {req, qual} = 76'h0;
    void'($urandom(32'hBD1B));
    rop = 16'($urandom_range(16'h00EF, 16'h0010));
    vT[1] = $urandom_range(4, 0);
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // Reset values, then an unmapped place both ways
    axi(0, `ITEL_OFF_CTRL, 32'h0000_0001, 2'b00);
    axi(0, `ITEL_OFF_STAT, `ITEL_STAT_RST, 2'b00);
    axi(0, 8'h1C, 32'h0000_0000, 2'b10);
    axi(1, 8'h1C, 32'h0000_0000, 2'b10);
    // Enable written: first start arms pending, second traces, third is quiet
    axi(1, `ITEL_OFF_STAT, TE, 2'b00);
    ev(START, qo(rop, 1'b1, 1'b1), 0, 6'h00);
    `CHK(tracePending, 1'b1)
    ev(START, qo(rop, 1'b1, 1'b1), 1, {`ITEL_EX_TRACE, 2'b10});
    `CHK(tracePending, 1'b0)
    ev(START, qo(rop, 1'b1, 1'b1), 0, 6'h00);
    // Bit-set enable: the next instruction arms pending, the second is traced
    ev(BSET, 0, 0, 6'h00);
    ev(START, qo(rop, 1'b1, 1'b1), 0, 6'h00);
    `CHK(excValid, 1'b0)
    `CHK(tracePending, 1'b1)
    ev(BCLR, 0, 0, 6'h00);
    ev(START, qo(rop, 1'b1, 1'b1), 1, {`ITEL_EX_TRACE, 2'b00});
    // Pending wins over an opcode that would fault
    axi(1, `ITEL_OFF_STAT, TE | TP, 2'b00);
    ev(START, qo(16'hFFFF, 1'b1, 1'b1), 1, {`ITEL_EX_TRACE, 2'b10});
    // Reserved, undefined, unprivileged, customer and breakpoint opcodes
    for (i = 0; i < 5; i++) ev(START, qo(oT[i], i != 1, i != 2), 1, {cT[i], 2'b00});
    // Every compatibility code
    for (i = 1; i < 7; i++) begin
      ev(CMPF, {18'h3, 3'(i), 40'h0}, 1, {`ITEL_EX_COMPAT, 2'b00});
      `CHK(excCode, 32'(i))
    end
    // Compatibility mode turns a reserved opcode into code zero
    axi(1, `ITEL_OFF_STAT, 32'h8000_0000, 2'b00);
    ev(START, qo(16'hFFFF, 1'b1, 1'b1), 1, {`ITEL_EX_COMPAT, 2'b00});
    `CHK(excCode, `ITEL_CC_RSVOPC)
    // Faults and mid interrupts clear pending, aborts and late interrupts keep it
    for (i = 0; i < 6; i++) begin
      axi(1, `ITEL_OFF_STAT, TE | TP, 2'b00);
      ev(OPDF - i, 0, 1, {i == 0 ? `ITEL_EX_RSVOPD_F : i == 1 ? `ITEL_EX_RSVOPD_A : 4'hF, 1'b1, 1'(i % 2)});
    end
    // Change mode saves both bits and clears the live ones
    axi(1, `ITEL_OFF_STAT, TE, 2'b00);
    ev(CHM, 0, 1, {4'hF, 2'b11});
    `CHK({traceEnable, tracePending}, 2'b00)
    // Processor register screening, bad and legal values
    for (i = 0; i < 4; i++) ev(MOVE_TO_PROCESSOR_REGISTER, {23'h0, nT[i], vT[i]}, i % 2 == 0, {`ITEL_EX_RSVOPD_F, 2'b00});
    // Return with pending in the restored status
    ev(RETURN_FROM_EXCEPTION, {21'h0, 1'b1, 39'h0}, 0, 6'h00);
    `CHK(tracePending, 1'b1)
    ev(START, qo(rop, 1'b1, 1'b1), 1, {`ITEL_EX_TRACE, 2'b00});
    // Call leaves the live enable alone
    axi(1, `ITEL_OFF_STAT, TE, 2'b00);
    ev(CALL, 0, 0, 6'h00);
    `CHK(traceEnable, 1'b1)
    `CHK(expQ.size(), 0)
    conclude();
  end
endmodule
